// ==== logic/ocm_axil_slave.sv ====
// Purpose: AXI4-Lite slave front end with a simple register strobe port
// Assumes: decode and read data are supplied combinationally by the parent
// Notes: one write and one read in flight; address and data taken in any order
`timescale 1ns/1ns
`default_nettype none
module ocm_axil_slave #(
  parameter int unsigned AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_have_q;
  logic w_have_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;
  logic rvalid_d;

  // ==========================================================================
  // write channel
  // ==========================================================================
  // readies leave from flops, so each is loaded with what the plain decode would show next cycle
  assign aw_have_d = (s_axi_awvalid && s_axi_awready) || (aw_have_q && !wr_en);
  assign w_have_d = (s_axi_wvalid && s_axi_wready) || (w_have_q && !wr_en);
  assign bvalid_d = wr_en || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_d = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
  assign wr_en = aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_have_d && !bvalid_d;
      s_axi_wready <= !w_have_d && !bvalid_d;
    end
  end
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_en) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ocm_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? ocm_pkg::RESP_SLVERR : ocm_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // read channel
  // ==========================================================================
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ocm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_err ? 32'h00000000 : rd_data;
      s_axi_rresp <= rd_err ? ocm_pkg::RESP_SLVERR : ocm_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ocm_axil_slave
`default_nettype wire

// ==== logic/ocm_group_mux.sv ====
// Purpose: two-stage source selector for one output group
// Assumes: sources are levels sampled in the aclk domain
// Notes: purely combinational; the top registers the result
`timescale 1ns/1ns
`default_nettype none
module ocm_group_mux (
  input wire ocm_pkg::ocm_src_t src,
  input wire ocm_pkg::ocm_sel_t sel,
  input wire logic loop_enable,
  output logic [2:0] eff_second,
  output logic mux_out
);
  logic first_out;

  // ==========================================================================
  // first stage
  // ==========================================================================
  always_comb begin
    unique case (sel.first)
      ocm_pkg::FS_REF_PRE: first_out = src.loop_ref_pre;
      ocm_pkg::FS_REF_POST: first_out = src.loop_ref_post;
      ocm_pkg::FS_IN_BUF2: first_out = src.input_buffer_two;
      ocm_pkg::FS_IN_BUF3: first_out = src.input_buffer_three;
    endcase
  end

  // ==========================================================================
  // second stage, forced to the first-stage path while the loop is off
  // ==========================================================================
  always_comb begin
    eff_second = loop_enable ? sel.second : ocm_pkg::SS_FIRST_STAGE;
    if (eff_second == ocm_pkg::SS_FIRST_STAGE) begin
      mux_out = first_out;
    end else if (eff_second == ocm_pkg::SS_INT_DIV0) begin
      mux_out = src.integer_divider[0];
    end else if (eff_second == ocm_pkg::SS_INT_DIV1) begin
      mux_out = src.integer_divider[1];
    end else begin
      mux_out = src.fast_divider[eff_second];
    end
  end
endmodule // ocm_group_mux
`default_nettype wire

// ==== logic/ocm_output_mux_select.sv ====
// Purpose: selector registers and output routing for output groups two to five
// Assumes: all clock sources are levels synchronous to aclk; package variant strap is static
// Notes: outputs zero and one belong to other groups and are held low here
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module ocm_output_mux_select #(
  parameter int unsigned AW = ocm_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ocm_pkg::ocm_src_t clk_src,
  input wire logic [1:0] package_variant_strap,
  output logic [ocm_pkg::NUM_OUTPUTS-1:0] out_clk_q
);
  localparam int unsigned NG = ocm_pkg::NUM_GROUPS;
  localparam int unsigned NO = ocm_pkg::NUM_OUTPUTS;
  localparam logic [2:0] NO_GROUP = 3'h7;

  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  ocm_pkg::ocm_sel_t sel_q [NG];
  logic loop_en_q;
  ocm_pkg::ocm_variant_t variant_q;
  logic variant_caught_q;
  logic [2:0] eff_second [NG];
  logic [NG-1:0] group_out;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;

  // ==========================================================================
  // bus front end
  // ==========================================================================
  ocm_axil_slave #(
    .AW(AW)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_idx = wr_addr[7:2];
  assign rd_idx = rd_addr[7:2];

  function automatic logic idx_mapped(input logic [5:0] idx, input logic allow_status);
    idx_mapped = (idx >= ocm_pkg::IDX_GROUP2 && idx <= ocm_pkg::IDX_GROUP5)
      || idx == ocm_pkg::IDX_LOOP_CTRL || (allow_status && idx == ocm_pkg::IDX_STATUS);
  endfunction

  // status is read only, so a write to it is refused
  assign wr_err = !idx_mapped(wr_idx, 1'b0);
  assign rd_err = !idx_mapped(rd_idx, 1'b1);

  // ==========================================================================
  // selector registers, one byte-wide register per group
  // ==========================================================================
  for (genvar g = 0; g < NG; g++) begin : g_sel
    localparam logic [5:0] MY_IDX = ocm_pkg::IDX_GROUP2 + 6'(g);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sel_q[g].first <= ocm_pkg::FIRST_RESET;
        sel_q[g].second <= ocm_pkg::SECOND_RESET;
      end else if (wr_en && wr_idx == MY_IDX && wr_strb[0]) begin
        sel_q[g].first <= wr_data[ocm_pkg::FIRST_LSB +: ocm_pkg::FIRST_W];
        sel_q[g].second <= wr_data[ocm_pkg::SECOND_LSB +: ocm_pkg::SECOND_W];
      end
    end

    ocm_group_mux u_mux (
      .src(clk_src),
      .sel(sel_q[g]),
      .loop_enable(loop_en_q),
      .eff_second(eff_second[g]),
      .mux_out(group_out[g])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_en_q <= ocm_pkg::LOOP_EN_RESET;
    end else if (wr_en && wr_idx == ocm_pkg::IDX_LOOP_CTRL && wr_strb[0]) begin
      loop_en_q <= wr_data[ocm_pkg::LOOP_EN_BIT];
    end
  end

  // ==========================================================================
  // package variant, caught once in the first cycle after reset release
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      variant_caught_q <= 1'b0;
      variant_q <= ocm_pkg::OCM_SMALL_PACKAGE_VARIANT;
    end else if (!variant_caught_q) begin
      variant_caught_q <= 1'b1;
      variant_q <= ocm_pkg::ocm_variant_t'(package_variant_strap);
    end
  end

  // ==========================================================================
  // read data
  // ==========================================================================
  always_comb begin
    rd_data = 32'h00000000;
    if (rd_idx >= ocm_pkg::IDX_GROUP2 && rd_idx <= ocm_pkg::IDX_GROUP5) begin
      rd_data[ocm_pkg::FIRST_LSB +: ocm_pkg::FIRST_W] = sel_q[2'(rd_idx - ocm_pkg::IDX_GROUP2)].first;
      rd_data[ocm_pkg::SECOND_LSB +: ocm_pkg::SECOND_W] = sel_q[2'(rd_idx - ocm_pkg::IDX_GROUP2)].second;
    end else if (rd_idx == ocm_pkg::IDX_LOOP_CTRL) begin
      rd_data[ocm_pkg::LOOP_EN_BIT] = loop_en_q;
    end else if (rd_idx == ocm_pkg::IDX_STATUS) begin
      // shows the code in use, which differs from the programmed one when forced
      rd_data[ocm_pkg::STATUS_LOOP_BIT] = loop_en_q;
      rd_data[ocm_pkg::STATUS_VARIANT_LSB +: 2] = variant_q;
      for (int g = 0; g < NG; g++) begin
        rd_data[ocm_pkg::STATUS_EFF_LSB + g * ocm_pkg::STATUS_EFF_STEP +: 3] = eff_second[g];
      end
    end
  end

  // ==========================================================================
  // output routing: which group drives each output in each variant
  // ==========================================================================
  // returns the group index relative to group two, or NO_GROUP
  function automatic logic [2:0] route(input ocm_pkg::ocm_variant_t v, input int unsigned n);
    route = NO_GROUP;
    unique case (v)
      ocm_pkg::OCM_MIDDLE_PACKAGE_VARIANT: begin
        if (n == 2 || n == 3) route = 3'h0;
        if (n == 4 || n == 5) route = 3'h1;
        if (n == 6) route = 3'h2;
        if (n == 7) route = 3'h3;
      end
      ocm_pkg::OCM_LARGE_PACKAGE_VARIANT: begin
        if (n >= 3 && n <= 5) route = 3'h0;
        if (n >= 6 && n <= 8) route = 3'h1;
        if (n == 9) route = 3'h2;
        if (n == 10 || n == 11) route = 3'h3;
      end
      // an unused strap code falls back to the smallest variant
      default: begin
        if (n >= 2 && n <= 5) route = 3'(n - 2);
      end
    endcase
  endfunction

  for (genvar n = 0; n < NO; n++) begin : g_out
    logic [2:0] grp;
    assign grp = route(variant_q, n);
    // registered so every pin leaves from a flop; costs one aclk of latency
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_clk_q[n] <= 1'b0;
      end else if (grp == NO_GROUP) begin
        out_clk_q[n] <= 1'b0;
      end else begin
        out_clk_q[n] <= group_out[grp[1:0]];
      end
    end
  end
endmodule // ocm_output_mux_select
`default_nettype wire

// ==== logic/ocm_pkg.sv ====
// Purpose: shared constants and types for the output clock mux selector block
// Assumes: AXI4-Lite with 32-bit data and byte addresses; one register per aligned word
// Notes: register index times four gives the byte address
package ocm_pkg;

  // ==========================================================================
  // register map (indices; byte address = index * 4)
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [5:0] IDX_GROUP2 = 6'h27;
  localparam logic [5:0] IDX_GROUP3 = 6'h28;
  localparam logic [5:0] IDX_GROUP4 = 6'h29;
  localparam logic [5:0] IDX_GROUP5 = 6'h2A;
  localparam logic [5:0] IDX_LOOP_CTRL = 6'h3D;
  localparam logic [5:0] IDX_STATUS = 6'h3E;
  localparam int unsigned FIRST_GROUP = 2;
  localparam int unsigned NUM_GROUPS = 4;
  localparam int unsigned NUM_OUTPUTS = 12;

  // ==========================================================================
  // field layout and reset values
  // ==========================================================================
  localparam int unsigned FIRST_LSB = 0;
  localparam int unsigned FIRST_W = 2;
  localparam int unsigned SECOND_LSB = 4;
  localparam int unsigned SECOND_W = 3;
  localparam int unsigned LOOP_EN_BIT = 0;
  localparam int unsigned STATUS_LOOP_BIT = 0;
  localparam int unsigned STATUS_VARIANT_LSB = 4;
  localparam int unsigned STATUS_EFF_LSB = 8;
  localparam int unsigned STATUS_EFF_STEP = 4;
  localparam logic [1:0] FIRST_RESET = 2'h0;
  localparam logic [2:0] SECOND_RESET = 3'h7;
  localparam logic LOOP_EN_RESET = 1'b0;

  // ==========================================================================
  // selector codes
  // ==========================================================================
  localparam logic [1:0] FS_REF_PRE = 2'h0;
  localparam logic [1:0] FS_REF_POST = 2'h1;
  localparam logic [1:0] FS_IN_BUF2 = 2'h2;
  localparam logic [1:0] FS_IN_BUF3 = 2'h3;
  localparam logic [2:0] SS_INT_DIV0 = 3'h5;
  localparam logic [2:0] SS_INT_DIV1 = 3'h6;
  localparam logic [2:0] SS_FIRST_STAGE = 3'h7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OCM_SMALL_PACKAGE_VARIANT,
    OCM_MIDDLE_PACKAGE_VARIANT,
    OCM_LARGE_PACKAGE_VARIANT,
    OCM_VARIANT_UNUSED
  } ocm_variant_t;

  // clock sources seen by every group mux, all sampled in the aclk domain
  typedef struct packed {
    logic loop_ref_pre;
    logic loop_ref_post;
    logic input_buffer_two;
    logic input_buffer_three;
    logic [4:0] fast_divider;
    logic [1:0] integer_divider;
  } ocm_src_t;

  typedef struct packed {
    logic [2:0] second;
    logic [1:0] first;
  } ocm_sel_t;

endpackage

// ==== verification/ocm_output_mux_select_sva.sv ====
// Purpose: protocol and routing checks at the ports of the group selector block
// Assumes: package variant strap only changes while reset is held
// Notes: routing checks wait three edges after reset so the captured strap has reached out_clk_q
`timescale 1ns/1ns
`default_nettype none
module ocm_output_mux_select_sva #(
  parameter int unsigned AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] package_variant_strap,
  input wire logic [ocm_pkg::NUM_OUTPUTS-1:0] out_clk_q
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  logic [1:0] settle_q;
  logic ar_hs;
  logic [11:0] o;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign o = out_clk_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) settle_q <= 2'h0;
    else if (settle_q != 2'h3) settle_q <= settle_q + 2'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // bus
  // ==========================================================================
  property p_bresp_time;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_bresp_time: assert property (p_bresp_time) else $error("write answer late or early");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_unmapped_rd;
    ar_hs && s_axi_araddr == 8'h00 |=> s_axi_rvalid && s_axi_rresp == ocm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not refused");
  property p_forced;
    ar_hs && s_axi_araddr == 8'hF8 |=> s_axi_rresp == ocm_pkg::RESP_OKAY && (s_axi_rdata[0] ||
      (s_axi_rdata[10:8] == 3'h7 && s_axi_rdata[14:12] == 3'h7 && s_axi_rdata[18:16] == 3'h7 &&
      s_axi_rdata[22:20] == 3'h7));
  endproperty
  a_forced: assert property (p_forced) else $error("second stage not forced while loop off");
  // ==========================================================================
  // routing per package variant
  // ==========================================================================
  property p_low_outputs;
    o[1:0] == 2'h0;
  endproperty
  a_low_outputs: assert property (p_low_outputs) else $error("outputs of other groups driven");
  property p_small_map;
    settle_q == 2'h3 && (package_variant_strap == 2'h0 || package_variant_strap == 2'h3) |-> o[11:6] == 6'h00;
  endproperty
  a_small_map: assert property (p_small_map) else $error("small variant drives unused outputs");
  property p_mid_map;
    settle_q == 2'h3 && package_variant_strap == 2'h1 |-> o[4] == o[5] && o[2] == o[3] && o[11:8] == 4'h0;
  endproperty
  a_mid_map: assert property (p_mid_map) else $error("middle variant routing wrong");
  property p_large_map;
    settle_q == 2'h3 && package_variant_strap == 2'h2 |-> o[2] == 1'b0 && o[6] == o[7] && o[7] == o[8] &&
      o[10] == o[11] && o[3] == o[4] && o[4] == o[5];
  endproperty
  a_large_map: assert property (p_large_map) else $error("large variant routing wrong");
  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == ocm_pkg::RESP_OKAY);
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == ocm_pkg::RESP_SLVERR);
  c_large: cover property (package_variant_strap == 2'h2 && o[11]);
endmodule // ocm_output_mux_select_sva
bind ocm_output_mux_select ocm_output_mux_select_sva #(.AW(AW)) u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .package_variant_strap(package_variant_strap),
  .out_clk_q(out_clk_q));
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the output group selector block
// Assumes: bready and rready are held high throughout, which the bus allows
// Notes: strap changes only inside reset; handshakes are sampled at the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [10:0] src;
    logic [11:0] exp;
  } ocm_row_t;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, strap, r;
  ocm_pkg::ocm_src_t clk_src;
  logic [11:0] out_clk_q;
  int fail_count, compares, cycles;
  ocm_row_t rows [15];
  logic [11:0] m3 [4], m4 [4], m5 [4];
  ocm_output_mux_select DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .clk_src(clk_src),
    .package_variant_strap(strap), .out_clk_q(out_clk_q));
  // ==========================================================================
  // clock, timeout, verdict
  // ==========================================================================
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ==========================================================================
  // bus and compare tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s, output logic [1:0] resp);
    logic ha, hw, hb;
    awaddr <= a;
    wdata <= dat;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (hb !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid;
      dat = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (hr !== 1'b1);
  endtask
  task automatic chk_out(input logic [10:0] src, input logic [11:0] exp);
    clk_src <= src;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({20'h0, out_clk_q}, {20'h0, exp});
    @(posedge aclk);
  endtask
  task automatic rst(input logic [1:0] v);
    aresetn <= 1'b0;
    strap <= v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // ==========================================================================
  // sequence
  // ==========================================================================
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb, clk_src} = '0;
    {strap, fail_count, compares} = '0;
    aresetn = 1'b0;
    rows = '{'{8'h9C, 32'h70, 11'h400, 12'h03C}, '{8'h9C, 32'h71, 11'h200, 12'h004},
      '{8'h9C, 32'h72, 11'h100, 12'h004}, '{8'h9C, 32'h73, 11'h080, 12'h004},
      '{8'hA0, 32'h00, 11'h004, 12'h008}, '{8'hA0, 32'h10, 11'h008, 12'h008},
      '{8'hA0, 32'h20, 11'h010, 12'h008}, '{8'hA0, 32'h30, 11'h020, 12'h008},
      '{8'hA0, 32'h40, 11'h040, 12'h008}, '{8'hA0, 32'h50, 11'h001, 12'h008},
      '{8'hA0, 32'h60, 11'h002, 12'h008}, '{8'hA4, 32'h72, 11'h100, 12'h010},
      '{8'hA8, 32'h01, 11'h004, 12'h020}, '{8'hA8, 32'h00, 11'h7FB, 12'h01C}, '{8'hA4, 32'h72, 11'h000, 12'h000}};
    m3 = '{12'h008, 12'h030, 12'h1C0, 12'h008};
    m4 = '{12'h010, 12'h040, 12'h200, 12'h010};
    m5 = '{12'h020, 12'h080, 12'hC00, 12'h020};
    rst(2'h0);
    rd(8'hA0, d, r);
    chk(d, 32'h70);
    rd(8'hF4, d, r);
    chk(d, 32'h0);
    wr(8'hF4, 32'h1, 4'hF, r);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, 4'hF, r);
      chk(r, ocm_pkg::RESP_OKAY);
      rd(rows[i].a, d, r);
      chk(d, rows[i].d);
      chk_out(rows[i].src, rows[i].exp);
    end
    // a cleared byte lane must not store
    wr(8'hA0, 32'h10, 4'h0, r);
    rd(8'hA0, d, r);
    chk(d, 32'h60);
    rd(8'hF8, d, r);
    chk(d, 32'h00076701);
    wr(8'hF4, 32'h0, 4'hF, r);
    chk_out(11'h400, 12'h028);
    rd(8'hF8, d, r);
    chk(d, 32'h00777700);
    rd(8'h00, d, r);
    chk({r, d[29:0]}, {ocm_pkg::RESP_SLVERR, 30'h0});
    wr(8'hF8, 32'h0, 4'hF, r);
    chk(r, ocm_pkg::RESP_SLVERR);
    wr(8'h00, 32'h0, 4'hF, r);
    chk(r, ocm_pkg::RESP_SLVERR);
    // each variant needs its own reset, since the strap is captured once
    for (int v = 0; v < 4; v++) begin
      rst(v[1:0]);
      wr(8'hA0, 32'h71, 4'hF, r);
      chk_out(11'h200, m3[v]);
      wr(8'hA4, 32'h72, 4'hF, r);
      chk_out(11'h100, m4[v]);
      wr(8'hA8, 32'h73, 4'hF, r);
      chk_out(11'h080, m5[v]);
    end
    print_verdict();
  end
endmodule // tb
`default_nettype wire
